//--- ifols_ctrl_model.sv
module ifols_ctrl_model
   import ifols_pkg::*;
(
   input  wire logic i_ref_clk,
   input  wire logic i_fault_out,
   input  wire logic i_fault_oe,
   output logic      o_mode_latch,
   output logic      o_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // The external pull-up gives a high level whenever the pin is released.
   assign o_pin = i_fault_oe ? i_fault_out : 1'b1;

   initial
   begin
      o_mode_latch = 1'b0;
   end

   // Drives the mode input on a falling edge and lets it pass the synchroniser.
   task automatic set_mode(input logic m);
      @(negedge i_ref_clk);
      o_mode_latch = m;
      repeat (4) @(negedge i_ref_clk);
   endtask : set_mode

   // Holds the mode input low past the clear time, then re-arms latching.
   task automatic clear_latch();
      @(negedge i_ref_clk);
      o_mode_latch = 1'b0;
      repeat (LATCH_CLR_CYC + 4) @(negedge i_ref_clk);
      o_mode_latch = 1'b1;
      repeat (4) @(negedge i_ref_clk);
   endtask : clear_latch
endmodule : ifols_ctrl_model

//--- ifols_pkg.sv
package ifols_pkg;

   localparam int unsigned CLK_FREQ_MHZ        = 125;
   localparam int unsigned LATCH_CLR_MIN_NS    = 4000;
   localparam int unsigned HS_FAULT_DELAY_NS   = 10000;
   localparam int unsigned HS_BLANK_TIME_NS    = 20000;
   localparam int unsigned HS_STARTUP_TIME_NS  = 8000;
   localparam int unsigned LS_STARTUP_TIME_NS  = 8000;
   localparam int unsigned NS_PER_US           = 1000;

   localparam int unsigned LATCH_CLR_CYC  = (LATCH_CLR_MIN_NS * CLK_FREQ_MHZ + NS_PER_US - 1)
                                            / NS_PER_US;
   localparam int unsigned HS_FLT_CYC     = (HS_FAULT_DELAY_NS * CLK_FREQ_MHZ) / NS_PER_US;
   localparam int unsigned HS_BLK_CYC     = (HS_BLANK_TIME_NS * CLK_FREQ_MHZ) / NS_PER_US;
   localparam int unsigned HS_STA_CYC     = (HS_STARTUP_TIME_NS * CLK_FREQ_MHZ) / NS_PER_US;
   localparam int unsigned LS_STA_CYC     = (LS_STARTUP_TIME_NS * CLK_FREQ_MHZ) / NS_PER_US;

   localparam int unsigned TMR_W = 16;

   typedef enum logic [1:0] {
      IFOLS_OUT_HIZ   = 2'b00,
      IFOLS_OUT_LOW   = 2'b01,
      IFOLS_OUT_CMP   = 2'b10
   } ifols_out_e;

   typedef enum logic [1:0] {
      IFOLS_HS_OFF    = 2'b00,
      IFOLS_HS_BOOT   = 2'b01,
      IFOLS_HS_UP     = 2'b10
   } ifols_hs_e;

   typedef struct packed {
      logic hs_pwr_ok;
      logic hs_uv;
      logic ls_uv;
   } ifols_supply_s;

endpackage : ifols_pkg

//--- ifols_sync.sv
module ifols_sync
   import ifols_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Two-stage synchroniser; the first stage feeds only the second.
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;

endmodule : ifols_sync

//--- ifols_timer.sv
module ifols_timer
   import ifols_pkg::*;
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_run,
   input  wire logic [TMR_W-1:0] i_limit,
   output logic                  o_done
);

   logic [TMR_W-1:0] cnt_ff;
   logic [TMR_W-1:0] nxt_cnt;
   logic             done_ff;
   logic             nxt_done;

   // Counts while running, restarts whenever the run level drops.
   always_comb
   begin
      nxt_cnt  = cnt_ff;
      nxt_done = done_ff;
      if (!i_run)
      begin
         nxt_cnt  = '0;
         nxt_done = 1'b0;
      end
      else if (cnt_ff >= i_limit - TMR_W'(1))
      begin
         nxt_done = 1'b1;
      end
      else
      begin
         nxt_cnt = cnt_ff + TMR_W'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign o_done = done_ff;

endmodule : ifols_timer

//--- ifols_top.sv
// Operation
// - Mode input high selects latching output.
// - Mode input low makes output follow comparator.
// - Out-of-range input drives fault output low.
// - Transparent mode releases output when back in range.
// - Latch mode holds output low after fault.
// - Clear releases only if input back in range.
// - Output is high impedance at low-side power-up.
// - Dead high side after startup plus delay forces low.
// - Long high-side undervoltage forces output low.
// - Comparator state withheld until high-side blanking ends.
// - Output waits high-side startup plus blanking.
// - Low-side undervoltage puts output high impedance immediately.
// - High side up: normal after low-side startup.
// - Short high-side undervoltage leaves output unaffected.
// - High-side undervoltage recovery resumes normal operation at once.
// - Power loss: low after delay, resume after boot.
// - Window or positive-only comparator by reference level.
module ifols_top
   import ifols_pkg::*;
(
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   input  wire logic i_mode_latch,
   input  wire logic i_pos_cmp_trip,
   input  wire logic i_neg_cmp_trip,
   input  wire logic i_pos_only_mode,
   input  wire logic i_hs_pwr_ok,
   input  wire logic i_hs_uv,
   input  wire logic i_ls_uv,
   output logic      o_fault_out,
   output logic      o_fault_oe
);

   logic [5:0]    sync_bus;
   ifols_supply_s sup;
   logic          mode_latch;
   logic          pos_trip;
   logic          neg_trip;
   logic          pos_only;

   ifols_sync #(
      .WIDTH (6)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_async   ({i_mode_latch, i_pos_cmp_trip, i_neg_cmp_trip, i_pos_only_mode,
                   i_hs_pwr_ok, i_hs_uv}),
      .o_sync    (sync_bus)
   );

   logic ls_uv_meta_ff;
   logic ls_uv_ff;

   // Low-side undervoltage is separately synchronised and set during reset.
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ls_uv_meta_ff <= 1'b1;
         ls_uv_ff      <= 1'b1;
      end
      else
      begin
         ls_uv_meta_ff <= i_ls_uv;
         ls_uv_ff      <= ls_uv_meta_ff;
      end
   end

   assign mode_latch    = sync_bus[5];
   assign pos_trip      = sync_bus[4];
   assign neg_trip      = sync_bus[3];
   assign pos_only      = sync_bus[2];
   assign sup.hs_pwr_ok = sync_bus[1];
   assign sup.hs_uv     = sync_bus[0];
   assign sup.ls_uv     = ls_uv_ff;

   // Negative comparator ignored in positive-only mode.
   logic out_of_range;
   assign out_of_range = pos_trip | (neg_trip & ~pos_only);

   // High-side boot state: startup plus blanking after power returns.
   ifols_hs_e hs_st_ff;
   ifols_hs_e nxt_hs_st;
   logic      boot_done;
   logic      flt_done;
   logic      ls_done;
   logic      hs_bad;

   assign hs_bad = ~sup.hs_pwr_ok | sup.hs_uv | (hs_st_ff != IFOLS_HS_UP);

   always_comb
   begin
      nxt_hs_st = hs_st_ff;
      case (hs_st_ff)
         IFOLS_HS_OFF:
         begin
            if (sup.hs_pwr_ok && !sup.hs_uv)
            begin
               nxt_hs_st = IFOLS_HS_BOOT;
            end
         end
         IFOLS_HS_BOOT:
         begin
            if (!sup.hs_pwr_ok)
            begin
               nxt_hs_st = IFOLS_HS_OFF;
            end
            else if (boot_done)
            begin
               nxt_hs_st = IFOLS_HS_UP;
            end
         end
         IFOLS_HS_UP:
         begin
            if (!sup.hs_pwr_ok)
            begin
               nxt_hs_st = IFOLS_HS_OFF;
            end
         end
         default:
         begin
            nxt_hs_st = IFOLS_HS_OFF;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         hs_st_ff <= IFOLS_HS_OFF;
      end
      else
      begin
         hs_st_ff <= nxt_hs_st;
      end
   end

   // Timers restart whenever their supply condition drops.
   ifols_timer u_boot_tmr (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_run     (hs_st_ff == IFOLS_HS_BOOT),
      .i_limit   (TMR_W'(HS_STA_CYC + HS_BLK_CYC)),
      .o_done    (boot_done)
   );

   ifols_timer u_flt_tmr (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_run     (hs_bad & ls_done),
      .i_limit   (TMR_W'(HS_FLT_CYC)),
      .o_done    (flt_done)
   );

   ifols_timer u_ls_tmr (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_run     (~sup.ls_uv),
      .i_limit   (TMR_W'(LS_STA_CYC)),
      .o_done    (ls_done)
   );

   // Latch-clear qualifier: mode low for at least the clear time.
   logic clr_done;
   ifols_timer u_clr_tmr (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_run     (~mode_latch),
      .i_limit   (TMR_W'(LATCH_CLR_CYC)),
      .o_done    (clr_done)
   );

   // Output mode and latched fault.
   ifols_out_e out_st_ff;
   ifols_out_e nxt_out_st;
   logic       latched_ff;
   logic       nxt_latched;
   logic       nxt_drive_low;
   logic       nxt_oe;
   logic       pull_ff;
   logic       nxt_pull;
   logic       data_ff;

   always_comb
   begin
      nxt_out_st = out_st_ff;
      if (sup.ls_uv)
      begin
         nxt_out_st = IFOLS_OUT_HIZ;
      end
      else if (!ls_done)
      begin
         nxt_out_st = IFOLS_OUT_HIZ;
      end
      else if (!hs_bad)
      begin
         nxt_out_st = IFOLS_OUT_CMP;
      end
      else if (flt_done)
      begin
         nxt_out_st = IFOLS_OUT_LOW;
      end
      else
      begin
         nxt_out_st = out_st_ff;
      end
   end

   always_comb
   begin
      nxt_latched = latched_ff;
      if (out_st_ff == IFOLS_OUT_CMP && mode_latch && out_of_range)
      begin
         nxt_latched = 1'b1;
      end
      else if (clr_done && !out_of_range)
      begin
         nxt_latched = 1'b0;
      end
      nxt_drive_low = 1'b0;
      nxt_oe        = 1'b0;
      case (nxt_out_st)
         IFOLS_OUT_HIZ:
         begin
            nxt_oe = 1'b0;
         end
         IFOLS_OUT_LOW:
         begin
            nxt_oe        = 1'b1;
            nxt_drive_low = 1'b1;
         end
         IFOLS_OUT_CMP:
         begin
            nxt_oe        = 1'b1;
            nxt_drive_low = out_of_range | latched_ff;
         end
         default:
         begin
            nxt_oe = 1'b0;
         end
      endcase
      nxt_pull = nxt_oe & nxt_drive_low;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         out_st_ff  <= IFOLS_OUT_HIZ;
         latched_ff <= 1'b0;
         pull_ff    <= 1'b0;
         data_ff    <= 1'b1;
      end
      else
      begin
         out_st_ff  <= nxt_out_st;
         latched_ff <= nxt_latched;
         pull_ff    <= nxt_pull;
         data_ff    <= ~nxt_pull;
      end
   end

   // Open-drain pin: data is low whenever the enable pulls the pin low.
   assign o_fault_out = data_ff;
   assign o_fault_oe  = pull_ff;

   a_ls_uv_hiz: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      sup.ls_uv |=> !o_fault_oe)
      else $error("Output driven during low-side undervoltage.");

   a_trip_low: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (out_st_ff == IFOLS_OUT_CMP && nxt_out_st == IFOLS_OUT_CMP && out_of_range)
      |=> o_fault_oe)
      else $error("Trip did not pull output low.");

   a_transp_rel: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (nxt_out_st == IFOLS_OUT_CMP && !out_of_range && !latched_ff && !nxt_latched)
      |=> !o_fault_oe)
      else $error("Transparent output not released.");

   a_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (latched_ff && mode_latch && nxt_out_st == IFOLS_OUT_CMP) |=> o_fault_oe)
      else $error("Latched fault released while armed.");

   a_clr_stay: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (latched_ff && out_of_range) |=> latched_ff)
      else $error("Latch cleared while out of range.");

   a_short_uv: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (out_st_ff == IFOLS_OUT_CMP && !flt_done && !sup.ls_uv) |=> out_st_ff == IFOLS_OUT_CMP)
      else $error("Short undervoltage changed output mode.");

   a_uv_recover: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (out_st_ff == IFOLS_OUT_LOW && !hs_bad && ls_done && !sup.ls_uv)
      |=> out_st_ff == IFOLS_OUT_CMP)
      else $error("No resume after recovery.");

   a_fault_low: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (flt_done && hs_bad && ls_done && !sup.ls_uv) |=> o_fault_oe)
      else $error("Supply fault did not pull output low.");

   c_latch: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
      latched_ff && !out_of_range && o_fault_oe);
   c_hs_fault: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
      out_st_ff == IFOLS_OUT_LOW);
   c_boot: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
      hs_st_ff == IFOLS_HS_BOOT ##1 hs_st_ff == IFOLS_HS_UP);

endmodule : ifols_top

//--- ifols_top_tb.sv
module ifols_top_tb;
   import ifols_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BOOT = HS_STA_CYC + HS_BLK_CYC;

   logic          i_ref_clk  = 1'b0;
   logic          i_rstn     = 1'b0;
   logic          pos        = 1'b0;
   logic          neg        = 1'b0;
   logic          pos_only   = 1'b0;
   ifols_supply_s sup        = 3'h3;
   logic          mode;
   logic          fout;
   logic          oe;
   logic          pin;
   int            err_count  = 0;
   int            num_checks = 0;

   always #4 i_ref_clk = ~i_ref_clk;

   ifols_top dut (
      .i_ref_clk       (i_ref_clk),
      .i_rstn          (i_rstn),
      .i_mode_latch    (mode),
      .i_pos_cmp_trip  (pos),
      .i_neg_cmp_trip  (neg),
      .i_pos_only_mode (pos_only),
      .i_hs_pwr_ok     (sup.hs_pwr_ok),
      .i_hs_uv         (sup.hs_uv),
      .i_ls_uv         (sup.ls_uv),
      .o_fault_out     (fout),
      .o_fault_oe      (oe)
   );

   ifols_ctrl_model ctrl (
      .i_ref_clk    (i_ref_clk),
      .i_fault_out  (fout),
      .i_fault_oe   (oe),
      .o_mode_latch (mode),
      .o_pin        (pin)
   );

   task automatic conclude();
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen %b expected %b", $time, seen, exp);
      end
   endtask : chk

   // Checks that the pull-down stays as expected for n cycles.
   task automatic stay(input int n, input logic exp);
      int i;
      for (i = 0; i < n; i++)
      begin
         @(negedge i_ref_clk);
         if (oe !== exp)
            break;
      end
      chk(oe, exp);
   endtask : stay

   // Waits a bounded time for the pull-down, then checks the pin level.
   task automatic wait_oe(input int n, input logic exp);
      int i;
      for (i = 0; i < n && oe !== exp; i++)
         @(negedge i_ref_clk);
      chk(oe, exp);
      chk(pin, ~exp);
      if (oe !== exp)
         conclude();
   endtask : wait_oe

   task automatic tdone(input string name);
      $display("test %s done, mismatches %0d", name, err_count);
   endtask : tdone

   initial
   begin
      repeat (16) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      chk(oe, 1'b0);
      sup.ls_uv = 1'b0;
      stay(LS_STA_CYC + HS_FLT_CYC - 10, 1'b0);
      wait_oe(20, 1'b1);
      sup = 3'h4;
      stay(BOOT - 10, 1'b1);
      wait_oe(20, 1'b0);
      tdone("power-up");
      for (int k = 0; k < 2; k++)
      begin
         {neg, pos} = k ? 2'h2 : 2'h1;
         wait_oe(8, 1'b1);
         {neg, pos} = 2'h0;
         wait_oe(8, 1'b0);
      end
      pos_only = 1'b1;
      neg = 1'b1;
      stay(12, 1'b0);
      pos = 1'b1;
      wait_oe(8, 1'b1);
      {pos_only, neg, pos} = 3'h0;
      wait_oe(8, 1'b0);
      tdone("transparent");
      ctrl.set_mode(1'b1);
      pos = 1'b1;
      wait_oe(8, 1'b1);
      pos = 1'b0;
      stay(20, 1'b1);
      pos = 1'b1;
      ctrl.clear_latch();
      pos = 1'b0;
      stay(20, 1'b1);
      ctrl.set_mode(1'b0);
      stay(LATCH_CLR_CYC - 10, 1'b1);
      wait_oe(20, 1'b0);
      ctrl.set_mode(1'b1);
      stay(20, 1'b0);
      pos = 1'b1;
      wait_oe(8, 1'b1);
      pos = 1'b0;
      stay(20, 1'b1);
      ctrl.clear_latch();
      wait_oe(8, 1'b0);
      stay(20, 1'b0);
      tdone("latch");
      ctrl.set_mode(1'b0);
      sup.hs_uv = 1'b1;
      stay(HS_FLT_CYC - 20, 1'b0);
      sup.hs_uv = 1'b0;
      stay(40, 1'b0);
      sup.hs_uv = 1'b1;
      stay(HS_FLT_CYC - 10, 1'b0);
      wait_oe(20, 1'b1);
      sup.hs_uv = 1'b0;
      wait_oe(8, 1'b0);
      sup = 3'h2;
      stay(HS_FLT_CYC - 10, 1'b0);
      wait_oe(20, 1'b1);
      sup = 3'h4;
      stay(BOOT - 10, 1'b1);
      wait_oe(20, 1'b0);
      tdone("high side supply");
      pos = 1'b1;
      wait_oe(8, 1'b1);
      sup.ls_uv = 1'b1;
      wait_oe(8, 1'b0);
      sup.ls_uv = 1'b0;
      stay(LS_STA_CYC - 10, 1'b0);
      wait_oe(20, 1'b1);
      tdone("low side supply");
      conclude();
   end
endmodule : ifols_top_tb
